// ---- logic/decoder_pkg.sv ----
package decoder_pkg;
   // register byte offsets on the bus
   localparam logic [15:0] OFS_INSTR    = 16'h0000;
   localparam logic [15:0] OFS_WORKING  = 16'h0004;
   localparam logic [15:0] OFS_STATUS   = 16'h0008;
   localparam logic [15:0] OFS_BANK     = 16'h000c;
   localparam logic [15:0] OFS_PTR0     = 16'h0010;
   localparam logic [15:0] OFS_PTR1     = 16'h0014;
   localparam logic [15:0] OFS_PTR2     = 16'h0018;
   localparam logic [15:0] OFS_TBLPTR   = 16'h001c;
   localparam logic [15:0] OFS_TBLLATCH = 16'h0020;
   localparam logic [15:0] OFS_PROD     = 16'h0024;
   localparam logic [15:0] OFS_PC       = 16'h0028;
   localparam logic [15:0] OFS_RETADDR  = 16'h002c;
   localparam logic [15:0] OFS_CTRL     = 16'h0030;
   localparam int          DMEM_BIT     = 14;        // haddr bit selecting data memory window
   // status and control field positions
   localparam int          STAT_BUSY    = 8;
   localparam int          STAT_PEND    = 9;
   localparam int          CTRL_EXT     = 0;
   localparam int          CTRL_PSA     = 1;
   // reset values
   localparam logic [7:0]  WORKING_RST  = 8'h00;
   localparam logic [3:0]  BANK_RST     = 4'h0;
   localparam logic [20:0] PC_RST       = 21'h000000;
   localparam logic [1:0]  CTRL_RST     = 2'h0;
   // opcode fields
   localparam logic [7:0]  OPC_ADD_LIT  = 8'h0f;
   localparam logic [7:0]  OPC_AND_LIT  = 8'h0b;
   localparam logic [7:0]  OPC_OR_LIT   = 8'h09;
   localparam logic [7:0]  OPC_MOVE_LIT = 8'h0e;
   localparam logic [7:0]  OPC_MUL_LIT  = 8'h0d;
   localparam logic [7:0]  OPC_RET_LIT  = 8'h0c;
   localparam logic [7:0]  OPC_SUB_LIT  = 8'h08;
   localparam logic [7:0]  OPC_XOR_LIT  = 8'h0a;
   localparam logic [9:0]  OPC_PTR_LOAD = 10'h3b8;   // 1110 1110 00
   localparam logic [7:0]  OPC_SECOND   = 8'hf0;     // 1111 0000
   localparam logic [11:0] OPC_BANK_LIT = 12'h010;   // 0000 0001 0000
   localparam logic [11:0] OPC_TBL      = 12'h000;
   localparam logic [1:0]  TBL_RD       = 2'h2;
   localparam logic [1:0]  TBL_WR       = 2'h3;
   localparam logic [5:0]  OPC_ADD_FILE = 6'h09;     // 0010 01
   // addressing
   localparam logic [7:0]  ACCESS_SPLIT = 8'h60;
   localparam logic [7:0]  INDEX_LIMIT  = 8'h5f;
   localparam logic [3:0]  ACCESS_HIGH  = 4'hf;
   localparam logic [11:0] PORT_ADDR    = 12'hf81;
   localparam logic [11:0] TIMER_ADDR   = 12'hfd6;

   typedef enum {st_idle, st_q1, st_q2, st_q3, st_q4} phase_t;
   typedef enum {op_nop, op_add_lit, op_and_lit, op_or_lit, op_xor_lit, op_sub_lit, op_move_lit,
                 op_mul_lit, op_ret_lit, op_bank_lit, op_ptr_load, op_tbl_read, op_tbl_write,
                 op_add_file} op_t;
   typedef struct packed {
      logic n;
      logic overflow;
      logic z;
      logic digit_carry;
      logic c;
   } flags_t;
   typedef struct packed {
      logic        sel;
      logic        wr;
      logic [15:0] addr;
   } bus_req_t;
endpackage : decoder_pkg

// ---- logic/literal_table_op_decoder.sv ----
`timescale 1ns/1ns
module literal_table_op_decoder (
   input  wire logic        hclk,        // 10 MHz bus clock
   input  wire logic        hresetn,     // asynchronous reset, active low
   input  wire logic        hsel,        // slave select
   input  wire logic [31:0] haddr,       // byte address
   input  wire logic [1:0]  htrans,      // transfer type
   input  wire logic        hwrite,      // write strobe
   input  wire logic [2:0]  hsize,       // transfer size
   input  wire logic [31:0] hwdata,      // write data
   input  wire logic        hready,      // bus ready
   output      logic [31:0] hrdata,      // read data
   output      logic        hreadyout,   // slave ready
   output      logic        hresp,       // response, always okay
   input  wire logic [7:0]  port_pins,   // pin levels of the port
   output      logic [7:0]  port_out,    // port output latch
   output      logic        tbl_req,     // table access pulse
   output      logic        tbl_write,   // table access is a write
   output      logic [20:0] tbl_addr,    // table address
   output      logic [7:0]  tbl_wdata,   // table write byte
   input  wire logic [7:0]  tbl_rdata,   // table read byte, same clock
   output      logic        prescale_clr // prescaler clear pulse
);
   import decoder_pkg::*;

   bus_req_t     areq;
   phase_t       phase;
   op_t          op;
   flags_t       flags, next_flags;
   logic [15:0]  ir;
   logic [7:0]   working_register, operand, next_result;
   logic [3:0]   bank_select_register;
   logic [11:0]  file_select_pointer [3];
   logic [20:0]  tblptr, pc, retaddr;
   logic [7:0]   tbllatch;
   logic [15:0]  prod;
   logic [1:0]   ctrl;
   logic         second, pending, needs_two;
   logic [1:0]   pend_sel;
   logic [3:0]   pend_hi;
   logic [7:0]   dmem [4096];
   logic [7:0]   pin_s1, pin_s2, pin_s3, pins;
   logic [11:0]  faddr;
   logic [8:0]   sum9;
   logic [4:0]   sum5;
   logic         instr_wr, wr_ok;
   logic [7:0]   lit;

   assign lit       = ir[7:0];
   assign instr_wr  = areq.sel && areq.wr && areq.addr == OFS_INSTR && phase == st_idle;
   assign wr_ok     = areq.sel && areq.wr && phase == st_idle;
   assign needs_two = op == op_ret_lit || op == op_tbl_read || op == op_tbl_write;

   // pin synchroniser; a change counts once stages two and three agree
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pin_s1 <= 8'h00;
         pin_s2 <= 8'h00;
         pin_s3 <= 8'h00;
         pins   <= 8'h00;
      end else begin
         pin_s1 <= port_pins;
         pin_s2 <= pin_s1;
         pin_s3 <= pin_s2;
         if (pin_s2 == pin_s3) pins <= pin_s3;
      end
   end

   // decode of the instruction word
   always_comb begin
      op = op_nop;
      if (pending) op = op_ptr_load;
      else if (ir[15:8] == OPC_ADD_LIT) op = op_add_lit;
      else if (ir[15:8] == OPC_AND_LIT) op = op_and_lit;
      else if (ir[15:8] == OPC_OR_LIT) op = op_or_lit;
      else if (ir[15:8] == OPC_XOR_LIT) op = op_xor_lit;
      else if (ir[15:8] == OPC_SUB_LIT) op = op_sub_lit;
      else if (ir[15:8] == OPC_MOVE_LIT) op = op_move_lit;
      else if (ir[15:8] == OPC_MUL_LIT) op = op_mul_lit;
      else if (ir[15:8] == OPC_RET_LIT) op = op_ret_lit;
      else if (ir[15:4] == OPC_BANK_LIT) op = op_bank_lit;
      else if (ir[15:6] == OPC_PTR_LOAD) op = op_ptr_load;
      else if (ir[15:4] == OPC_TBL && ir[3:2] == TBL_RD) op = op_tbl_read;
      else if (ir[15:4] == OPC_TBL && ir[3:2] == TBL_WR) op = op_tbl_write;
      else if (ir[15:10] == OPC_ADD_FILE) op = op_add_file;
   end

   // file address: indexed, access bank or banked
   always_comb begin
      if (!ir[8] && ctrl[CTRL_EXT] && ir[7:0] <= INDEX_LIMIT)
         faddr = file_select_pointer[2] + {4'h0, ir[7:0]};
      else if (!ir[8])
         faddr = (ir[7:0] < ACCESS_SPLIT) ? {4'h0, ir[7:0]} : {ACCESS_HIGH, ir[7:0]};
      else
         faddr = {bank_select_register, ir[7:0]};
   end

   // arithmetic and logic of the literal and file operations
   always_comb begin
      next_flags  = flags;
      next_result = working_register;
      sum9        = 9'h000;
      sum5        = 5'h00;
      case (op)
         op_add_lit, op_add_file: begin
            sum9 = {1'b0, working_register} + {1'b0, operand};
            sum5 = {1'b0, working_register[3:0]} + {1'b0, operand[3:0]};
            next_result   = sum9[7:0];
            next_flags.c  = sum9[8];
            next_flags.digit_carry = sum5[4];
            next_flags.overflow = (working_register[7] == operand[7]) && (sum9[7] != operand[7]);
         end
         op_sub_lit: begin
            sum9 = {1'b0, operand} + {1'b0, ~working_register} + 9'h001;
            sum5 = {1'b0, operand[3:0]} + {1'b0, ~working_register[3:0]} + 5'h01;
            next_result   = sum9[7:0];
            next_flags.c  = sum9[8];
            next_flags.digit_carry = sum5[4];
            next_flags.overflow = (operand[7] != working_register[7]) && (sum9[7] != operand[7]);
         end
         op_and_lit: next_result = working_register & operand;
         op_or_lit:  next_result = working_register | operand;
         op_xor_lit: next_result = working_register ^ operand;
         op_move_lit, op_ret_lit: next_result = operand;
         default: next_result = working_register;
      endcase
      if (op inside {op_add_lit, op_add_file, op_sub_lit, op_and_lit, op_or_lit, op_xor_lit}) begin
         next_flags.z = next_result == 8'h00;
         next_flags.n = next_result[7];
      end
   end

   // quarter-cycle sequencer; two-cycle operations run a second cycle, which only the table ops use (latch capture, pointer move)
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         phase  <= st_idle;
         second <= 1'b0;
      end else begin
         case (phase)
            st_idle: if (instr_wr) phase <= st_q1;
            st_q1:   phase <= st_q2;
            st_q2:   phase <= st_q3;
            st_q3:   phase <= st_q4;
            st_q4: begin
               if (needs_two && !second) begin
                  phase  <= st_q1;
                  second <= 1'b1;
               end else begin
                  phase  <= st_idle;
                  second <= 1'b0;
               end
            end
            default: phase <= st_idle;
         endcase
      end
   end

   // instruction word and two-word pairing
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ir       <= 16'h0000;
         pending  <= 1'b0;
         pend_sel <= 2'h0;
         pend_hi  <= 4'h0;
      end else begin
         if (instr_wr) ir <= hwdata[15:0];
         if (phase == st_q4 && op == op_ptr_load && !pending) begin
            pending  <= 1'b1;
            pend_sel <= ir[5:4];
            pend_hi  <= ir[3:0];
         end else if (phase == st_q4 && pending) begin
            pending <= 1'b0;
         end
      end
   end

   // operand fetch in the second quarter
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         operand <= 8'h00;
      end else if (phase == st_q2 && !second) begin
         if (op == op_add_file)
            operand <= (faddr == PORT_ADDR) ? pins : dmem[faddr];
         else
            operand <= lit;
      end
   end

   // working register, flags, product, bank
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         working_register     <= WORKING_RST;
         flags                <= '0;
         prod                 <= 16'h0000;
         bank_select_register <= BANK_RST;
      end else if (phase == st_q4 && !second) begin
         if (op != op_add_file || !ir[9]) working_register <= next_result;
         flags <= next_flags;
         if (op == op_mul_lit) prod <= working_register * operand;
         if (op == op_bank_lit) bank_select_register <= ir[3:0];
      end else if (wr_ok) begin
         if (areq.addr == OFS_WORKING) working_register <= hwdata[7:0];
         if (areq.addr == OFS_STATUS) flags <= hwdata[4:0];
         if (areq.addr == OFS_BANK) bank_select_register <= hwdata[3:0];
      end
   end

   // file select pointers, one per entry
   for (genvar i = 0; i < 3; i++) begin : g_ptr
      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            file_select_pointer[i] <= 12'h000;
         end else if (phase == st_q4 && pending && pend_sel == 2'(i)) begin
            file_select_pointer[i] <= {pend_hi, ir[7:0]};
         end else if (wr_ok && areq.addr == OFS_PTR0 + 16'(4 * i)) begin
            file_select_pointer[i] <= hwdata[11:0];
         end
      end
   end

   // data memory, port latch and prescaler clear
   always_ff @(posedge hclk) begin
      if (phase == st_q4 && !second && op == op_add_file && ir[9])
         dmem[faddr] <= next_result;
      else if (wr_ok && areq.addr[DMEM_BIT])
         dmem[areq.addr[13:2]] <= hwdata[7:0];
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         port_out     <= 8'h00;
         prescale_clr <= 1'b0;
      end else begin
         prescale_clr <= phase == st_q4 && !second && op == op_add_file && ir[9]
                         && faddr == TIMER_ADDR && ctrl[CTRL_PSA];
         if (phase == st_q4 && !second && op == op_add_file && ir[9] && faddr == PORT_ADDR)
            port_out <= next_result;
      end
   end

   // program counter and return
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pc      <= PC_RST;
         retaddr <= PC_RST;
         ctrl    <= CTRL_RST;
      end else if (phase == st_q4 && !second) begin
         pc <= (op == op_ret_lit) ? retaddr : pc + 21'h000002;
      end else if (wr_ok) begin
         if (areq.addr == OFS_PC) pc <= hwdata[20:0];
         if (areq.addr == OFS_RETADDR) retaddr <= hwdata[20:0];
         if (areq.addr == OFS_CTRL) ctrl <= hwdata[1:0];
      end
   end

   // table pointer moves, access request and latch capture
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tblptr    <= 21'h000000;
         tbllatch  <= 8'h00;
         tbl_req   <= 1'b0;
         tbl_write <= 1'b0;
         tbl_addr  <= 21'h000000;
         tbl_wdata <= 8'h00;
      end else begin
         tbl_req <= 1'b0;
         // only a running table op moves the pointer; the last word lingers in ir when idle
         if (phase != st_idle && (op == op_tbl_read || op == op_tbl_write)) begin
            if (phase == st_q2 && !second && ir[1:0] == 2'h3)
               tblptr <= tblptr + 21'h000001;
            if (phase == st_q3 && !second) begin
               tbl_req   <= 1'b1;
               tbl_write <= op == op_tbl_write;
               tbl_addr  <= tblptr;
               tbl_wdata <= tbllatch;
            end
            if (phase == st_q2 && second && op == op_tbl_read)
               tbllatch <= tbl_rdata;
            if (phase == st_q4 && second && ir[1:0] == 2'h1)
               tblptr <= tblptr + 21'h000001;
            if (phase == st_q4 && second && ir[1:0] == 2'h2)
               tblptr <= tblptr - 21'h000001;
         end else if (wr_ok) begin
            if (areq.addr == OFS_TBLPTR) tblptr <= hwdata[20:0];
            if (areq.addr == OFS_TBLLATCH) tbllatch <= hwdata[7:0];
         end
      end
   end

   // bus address phase capture, zero-wait read data
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         areq      <= '0;
         hrdata    <= 32'h00000000;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else if (hready) begin
         areq.sel  <= hsel && htrans[1];
         areq.wr   <= hwrite;
         areq.addr <= haddr[15:0];
         hrdata    <= 32'h00000000;
         if (hsel && htrans[1] && !hwrite) begin
            if (haddr[DMEM_BIT]) hrdata <= {24'h000000, dmem[haddr[13:2]]};
            else case (haddr[15:0])
               OFS_INSTR:    hrdata <= {16'h0000, ir};
               OFS_WORKING:  hrdata <= {24'h000000, working_register};
               OFS_STATUS:   hrdata <= {22'h000000, pending, phase != st_idle, 3'h0, flags};
               OFS_BANK:     hrdata <= {28'h0000000, bank_select_register};
               OFS_PTR0:     hrdata <= {20'h00000, file_select_pointer[0]};
               OFS_PTR1:     hrdata <= {20'h00000, file_select_pointer[1]};
               OFS_PTR2:     hrdata <= {20'h00000, file_select_pointer[2]};
               OFS_TBLPTR:   hrdata <= {11'h000, tblptr};
               OFS_TBLLATCH: hrdata <= {24'h000000, tbllatch};
               OFS_PROD:     hrdata <= {16'h0000, prod};
               OFS_PC:       hrdata <= {11'h000, pc};
               OFS_RETADDR:  hrdata <= {11'h000, retaddr};
               OFS_CTRL:     hrdata <= {30'h00000000, ctrl};
               default:      hrdata <= 32'h00000000;
            endcase
         end
      end
   end

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   a_single_cycle_ops:
   assert property (phase == st_q1 && !second && op inside {op_add_lit, op_sub_lit, op_and_lit}
                    |-> ##3 phase == st_q4 ##1 phase == st_idle)
      else $error("one-cycle literal op did not finish after four quarters");
   a_and_flags_only:
   assert property (phase == st_q4 && !second && op == op_and_lit
                    |=> flags.c == $past(flags.c) && flags.overflow == $past(flags.overflow)
                        && working_register == ($past(working_register) & $past(lit)))
      else $error("and literal changed carry or overflow or gave wrong result");
   a_move_no_flags:
   assert property (phase == st_q4 && !second && op inside {op_move_lit, op_mul_lit, op_bank_lit}
                    |=> $stable(flags))
      else $error("flags changed on a flag-free literal op");
   a_ret_two_cycles:
   assert property (phase == st_q1 && !second && op == op_ret_lit
                    |-> ##3 phase == st_q4 ##1 (phase == st_q1 && second) ##3 phase == st_q4
                        ##1 phase == st_idle)
      else $error("return literal did not take two cycles");
   a_ret_pc_load:
   assert property (phase == st_q4 && !second && op == op_ret_lit |=> pc == $past(retaddr))
      else $error("return literal did not restore the return address");
   a_sub_result:
   assert property (phase == st_q4 && !second && op == op_sub_lit
                    |=> working_register == 8'($past(lit) - $past(working_register)))
      else $error("subtract from literal gave a wrong difference");
   a_bank_load:
   assert property (phase == st_q4 && !second && op == op_bank_lit
                    |=> bank_select_register == $past(ir[3:0]))
      else $error("bank literal not loaded");
   a_tbl_req_once:
   assert property (phase == st_q1 && !second && op == op_tbl_read
                    |-> ##3 tbl_req && !tbl_write ##1 !tbl_req)
      else $error("table read request missing or stretched");
   a_tbl_post_dec:
   assert property (phase == st_q4 && second && op == op_tbl_write && ir[1:0] == 2'h2
                    |=> tblptr == $past(tblptr) - 21'h000001)
      else $error("table write code e did not post-decrement");
   a_ptr_pairing:
   assert property (phase == st_q4 && op == op_ptr_load && !pending |=> pending)
      else $error("pointer load first word did not arm the second word");
   a_prescale_clear:
   assert property (prescale_clr |-> $past(faddr == TIMER_ADDR && ir[9] && ctrl[CTRL_PSA]))
      else $error("prescaler cleared without a timer write");
endmodule : literal_table_op_decoder

// ---- verif/literal_table_op_decoder_tb_top.sv ----
`timescale 1ns/1ns
module literal_table_op_decoder_tb_top;
   import decoder_pkg::*;
   logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, clr_seen = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
   logic [1:0]  htrans = 2'h0;
   logic [2:0]  hsize = 3'h2;
   logic [7:0]  port_pins = 8'h5a, port_out, tbl_wdata, tbl_rdata;
   logic [20:0] tbl_addr;
   logic        hready, hreadyout, hresp, tbl_req, tbl_write, prescale_clr;
   int          miscompares = 0, samples_checked = 0;
   assign hready = hreadyout;
   literal_table_op_decoder literal_table_op_decoder_inst (.hclk, .hresetn, .hsel, .haddr,
      .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .port_pins,
      .port_out, .tbl_req, .tbl_write, .tbl_addr, .tbl_wdata, .tbl_rdata, .prescale_clr);
   table_mem_model table_mem_model_inst (.hclk, .tbl_req, .tbl_write, .tbl_addr, .tbl_wdata,
      .tbl_rdata);
   // clock and prescaler pulse catcher
   initial forever #50 hclk = ~hclk;
   always @(posedge hclk) if (prescale_clr === 1'b1) clr_seen <= 1'b1;
   // one single word transfer, held until hready
   task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] d,
                      output logic [31:0] r);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr  <= {16'h0, a};
      do @(posedge hclk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hready !== 1'b1);
      r = hrdata;
   endtask : bus
   task automatic cmp(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask : cmp
   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      logic [31:0] r;
      bus(1'b1, a, d, r);
   endtask : wr
   task automatic chk(input logic [15:0] a, input logic [31:0] exp);
      logic [31:0] r;
      bus(1'b0, a, 32'h0, r);
      cmp(r, exp);
   endtask : chk
   function automatic logic [15:0] dm(input logic [11:0] i);
      return 16'h4000 | {2'h0, i, 2'h0};
   endfunction : dm
   // issue one word, then poll busy under a bound
   task automatic exec(input logic [15:0] ins);
      logic [31:0] s;
      wr(OFS_INSTR, {16'h0, ins});
      repeat (20) begin
         bus(1'b0, OFS_STATUS, 32'h0, s);
         if (s[STAT_BUSY] === 1'b0) break;
      end
   endtask : exec
   // every literal op except return and bank from the same start, other flags preset to show which change
   task automatic t_literal();
      logic [7:0] opc [7] = '{OPC_ADD_LIT, OPC_AND_LIT, OPC_OR_LIT, OPC_XOR_LIT, OPC_SUB_LIT,
                              OPC_MOVE_LIT, OPC_MUL_LIT};
      logic [7:0] ew [7] = '{8'he1, 8'h24, 8'hbd, 8'h99, 8'h69, 8'ha5, 8'h3c};
      logic [4:0] es [7] = '{5'h12, 5'h0b, 5'h1b, 5'h1b, 5'h09, 5'h0b, 5'h0b};
      for (int i = 0; i < 7; i++) begin
         wr(OFS_WORKING, 32'h3c);
         wr(OFS_STATUS, 32'h0b);
         exec({opc[i], 8'ha5});
         chk(OFS_WORKING, {24'h0, ew[i]});
         chk(OFS_STATUS, {27'h0, es[i]});
      end
      chk(OFS_PROD, 32'h26ac);
   endtask : t_literal
   // return, bank, two-word pointer load and a lone second word
   task automatic t_control();
      wr(OFS_RETADDR, 32'h123);
      exec(16'h0c77);
      chk(OFS_WORKING, 32'h77);
      chk(OFS_PC, 32'h123);
      exec(16'h010a);
      chk(OFS_BANK, 32'ha);
      chk(OFS_STATUS, 32'h0b);
      exec(16'hee1a);
      exec(16'hf0bc);
      chk(OFS_PTR1, 32'habc);
      exec(16'hf055);
      chk(OFS_PTR1, 32'habc);
      chk(OFS_WORKING, 32'h77);
   endtask : t_control
   // all table read and write codes, pointer restored before each
   task automatic t_table();
      logic [7:0] ep [4] = '{8'h40, 8'h41, 8'h3f, 8'h41};
      logic [7:0] ea [4] = '{8'h40, 8'h40, 8'h40, 8'h41};
      for (int i = 0; i < 8; i++) begin
         wr(OFS_TBLPTR, 32'h40);
         wr(OFS_TBLLATCH, 32'(8'hc0 + i));
         exec(16'(8 + i));
         chk(OFS_TBLPTR, {24'h0, ep[i % 4]});
         if (i < 4) chk(OFS_TBLLATCH, {24'h0, ea[i] ^ 8'h5a});
         else cmp({24'h0, table_mem_model_inst.mem[ea[i % 4]]}, 32'(8'hc0 + i));
      end
   endtask : t_table
   // add w to file: destination, banks, port pins, timer prescaler, indexed mode
   task automatic t_file();
      wr(OFS_CTRL, 32'h2);
      wr(dm(12'h010), 32'hc2);
      wr(OFS_WORKING, 32'h17);
      exec(16'h2410);
      chk(OFS_WORKING, 32'hd9);
      exec(16'h2610);
      chk(dm(12'h010), 32'h9b);
      chk(OFS_STATUS, 32'h11);
      wr(OFS_BANK, 32'h2);
      wr(dm(12'h210), 32'h01);
      exec(16'h2510);
      chk(OFS_WORKING, 32'hda);
      exec(16'h2681);
      cmp({24'h0, port_out}, 32'h34);
      for (int d = 1; d >= 0; d--) begin
         clr_seen = 1'b0;
         exec(16'h24d6 | 16'(d << 9));
         cmp({31'h0, clr_seen}, 32'(d));
      end
      wr(OFS_CTRL, 32'h1);
      wr(OFS_PTR2, 32'h300);
      wr(dm(12'h305), 32'h10);
      wr(OFS_WORKING, 32'h0);
      exec(16'h2405);
      chk(OFS_WORKING, 32'h10);
   endtask : t_file
   task automatic test_done();
      $display("checks %0d, mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : test_done
   // reset, then the scenarios in turn
   initial begin
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      chk(16'h003c, 32'h0);
      t_literal();
      t_control();
      t_table();
      t_file();
      test_done();
   end
   // watchdog well past the expected few hundred cycles
   initial begin
      #2000000;
      miscompares++;
      test_done();
   end
endmodule : literal_table_op_decoder_tb_top

// ---- verif/table_mem_model.sv ----
`timescale 1ns/1ns
module table_mem_model (
   input  wire logic        hclk,      // core clock
   input  wire logic        tbl_req,   // access pulse
   input  wire logic        tbl_write, // access is a write
   input  wire logic [20:0] tbl_addr,  // byte address
   input  wire logic [7:0]  tbl_wdata, // byte to store
   output      logic [7:0]  tbl_rdata  // byte read back
);
   logic [7:0] mem [256];
   logic [2:0] hold = 3'h0;
   // fill with a pattern the bench can predict
   initial for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5a;
   // store writes; a read byte stands only for its sampling window
   always @(posedge hclk) begin
      if (tbl_req === 1'b1 && tbl_write === 1'b1) mem[tbl_addr[7:0]] <= tbl_wdata;
      if (tbl_req === 1'b1 && tbl_write === 1'b0) hold <= 3'h7;
      else if (hold != 3'h0) hold <= hold - 3'h1;
   end
   // outside the window show the inverse so a late sample cannot pass
   assign tbl_rdata = (hold != 3'h0) ? mem[tbl_addr[7:0]] : ~mem[tbl_addr[7:0]];
endmodule : table_mem_model
